/* File: rtl/rq_host_consts.svh */
`ifndef RQ_HOST_CONSTS_SVH
`define RQ_HOST_CONSTS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define RQ_A_CTRL 8'h00
`define RQ_A_SIDE 8'h04
`define RQ_A_PLEN 8'h08
`define RQ_A_SEED 8'h0C
`define RQ_A_ABEAT 8'h10
`define RQ_A_STAT 8'h14
`define RQ_A_TAG 8'h18
`define RQ_A_DESC0 8'h20
`define RQ_A_DESC1 8'h24
`define RQ_A_DESC2 8'h28
`define RQ_A_DESC3 8'h2C
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RQ_CTRL_GO 0
`define RQ_CTRL_ALIGN 1
`define RQ_CTRL_ZLEN 2
`define RQ_CTRL_ABORT 3
`define RQ_CTRL_AEND 4
`define RQ_SIDE_HEAD 0
`define RQ_SIDE_TAIL 4
`define RQ_SIDE_OFF 8
`define RQ_STAT_BUSY 0
`define RQ_STAT_ERR_BE 1
`define RQ_STAT_ERR_SIZE 2
`define RQ_STAT_DONE 8
`define RQ_TAG_CNT 8
`define RQ_D_LEN 64
`define RQ_D_TYPE 75
`define RQ_D_TAG 96
// ----------------------------------------------------------------
// request type codes and limits
// ----------------------------------------------------------------
`define RQ_T_MEM_RD 4'h0
`define RQ_T_MEM_WR 4'h1
`define RQ_T_MSG_FIRST 4'hC
`define RQ_PAGE_DW 12'h400
`define RQ_DESC_DW 4
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RQ_RST_W32 32'h0000_0000
`define RQ_RST_W11 11'h000
`define RQ_RST_W8 8'h00
`define RQ_RST_TAG 6'h00
`endif

/* File: rtl/rq_host_pkg.sv */
package rq_host_pkg;
  // sideband that travels with the first beat of each request
  typedef struct packed {
    logic discontinue;
    logic [2:0] addr_offset;
    logic [3:0] tail_dword_byte_mask;
    logic [3:0] head_dword_byte_mask;
  } request_sideband_t;

  // gray along idle -> send -> done; done -> idle flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_DONE = 2'b11
  } host_state_t;
endpackage

/* File: rtl/rq_beat_packer.sv */
`include "rq_host_consts.svh"
// builds the dword lanes of one beat from its index
module rq_beat_packer #(
  parameter int LANES = 8
) (
  input wire logic [7:0] beat,
  input wire logic aligned,
  input wire logic [2:0] offset,
  input wire logic [10:0] len,
  input wire logic [127:0] desc,
  input wire logic [31:0] seed,
  output logic [LANES*32-1:0] data,
  output logic [LANES-1:0] keep,
  output logic last,
  output logic pay_beat
);
  import rq_host_pkg::*;
  // descriptor beats: two on a 64-bit path, one on wider paths
  localparam int DB = (`RQ_DESC_DW + LANES - 1) / LANES;
  localparam logic [11:0] LW = 12'(LANES);
  logic [11:0] start;
  logic [11:0] total;
  logic [11:0] base;

  // ----------------------------------------------------------------
  // packet geometry
  // ----------------------------------------------------------------
  // aligned payload opens the beat after the descriptor, at any lane
  assign start = aligned ? 12'(DB * LANES) + {9'h000, offset}
                         : 12'(`RQ_DESC_DW);
  assign total = (len == 11'h000) ? 12'(`RQ_DESC_DW)
                                  : start + {1'b0, len};
  assign base = 12'({4'h0, beat}) * LW;
  assign last = (base + LW) >= total;
  assign pay_beat = (len != 11'h000) && ((base + LW) > start);

  // ----------------------------------------------------------------
  // lanes
  // ----------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [11:0] pos;
    assign pos = base + 12'(l);
    // keep runs unbroken from descriptor start to the payload end
    always_comb begin
      keep[l] = pos < total;
      if (pos < 12'(`RQ_DESC_DW)) begin
        data[32*l +: 32] = desc[32*pos[1:0] +: 32];
      end else if (pos >= start && pos < total) begin
        data[32*l +: 32] = seed + {20'h00000, pos - start};
      end else begin
        data[32*l +: 32] = 32'h0000_0000;
      end
    end
  end
endmodule

/* File: rtl/rq_host_ctrl.sv */
`include "rq_host_consts.svh"
// Behaviour
// - head and tail byte masks are driven valid from the first beat.
// - payload above the size limit or crossing 4 Kbyte is refused.
// - masks must be contiguous except memory writes of two dwords or less.
// - zero-length write sends one dummy dword with both masks zero.
// - aligned payload starts the beat after the descriptor, any lane.
// - aligned mode drives the first payload lane on the offset field.
// - reads are descriptor-only packets with the normal handshake.
// - descriptor-only packet is two beats on 64 bits, else one.
// - valid held all packet, last on final beat, keep over content.
// - zero-length read uses length one and both masks zero.
// - read offset picks the completion data start lane.
// - dword-aligned payload follows the descriptor with no gap.
// - I/O and config writes use head mask; atomics all bytes valid (here atomic masks pass as set).
// - aligned messages place payload at lane zero, offset zero.
// - after abort the packet may end at once or run to its end.
// - discontinue only with valid, held until ready is seen.
// - keep is contiguous and may hold zeros only in the last beat.
module rq_host_ctrl #(
  parameter int LANES = 8,
  parameter int MAX_PAYLOAD_DW = 256,
  parameter bit user_tag_mode_param = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [LANES*32-1:0] request_stream_data,
  output logic [LANES-1:0] request_stream_keep,
  output logic request_stream_last,
  output logic request_stream_valid,
  input wire logic request_stream_ready,
  output rq_host_pkg::request_sideband_t request_sideband_bus,
  input wire logic [5:0] allocated_tag_out,
  input wire logic allocated_tag_strobe
);
  import rq_host_pkg::*;

  localparam logic [11:0] MAX_DW = 12'(MAX_PAYLOAD_DW);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [4:1] ctrl_q, ctrl_d;
  logic [10:0] side_q, side_d;
  logic [10:0] plen_q, plen_d;
  logic [31:0] seed_q, seed_d;
  logic [7:0] abeat_q, abeat_d;
  logic [127:0] desc_q, desc_d;
  logic go_q, go_d;
  logic err_be_q, err_be_d;
  logic err_size_q, err_size_d;
  logic [7:0] done_q, done_d;
  logic [5:0] last_tag_q, last_tag_d;
  logic [7:0] tag_cnt_q, tag_cnt_d;
  logic [5:0] user_tag_q, user_tag_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  host_state_t st_q, st_d;
  logic [7:0] beat_q, beat_d;
  logic valid_q, valid_d;
  logic last_q, last_d;
  logic [LANES*32-1:0] data_q, data_d;
  logic [LANES-1:0] keep_q, keep_d;
  request_sideband_t sb_q, sb_d;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic [3:0] rtype;
  logic is_wr, is_rd, is_msg, zlen, busy;
  logic [10:0] eff_len;
  logic [3:0] head_m, tail_m;
  logic [2:0] eff_off;
  logic [127:0] eff_desc;
  logic be_bad, size_bad;

  function automatic logic contig4(input logic [3:0] m);
    logic [4:0] low;
    low = {1'b0, m & (~m + 4'h1)};
    return (({1'b0, m} + low) & {1'b0, m}) == 5'h00;
  endfunction

  assign rtype = desc_q[`RQ_D_TYPE +: 4];
  assign is_wr = rtype == `RQ_T_MEM_WR;
  assign is_rd = rtype == `RQ_T_MEM_RD;
  assign is_msg = rtype >= `RQ_T_MSG_FIRST;
  assign zlen = ctrl_q[`RQ_CTRL_ZLEN] & (is_wr | is_rd);
  assign busy = (st_q != ST_IDLE) | go_q;

  // zero-length write carries one dummy dword, reads carry none
  always_comb begin
    if (zlen | is_rd) begin
      eff_len = is_wr ? 11'h001 : 11'h000;
    end else begin
      eff_len = plen_q;
    end
  end

  // masks cleared for zero-length and messages; atomics pass as set
  assign head_m = (zlen | is_msg) ? 4'h0 : side_q[`RQ_SIDE_HEAD +: 4];
  assign tail_m = (zlen | is_msg) ? 4'h0 : side_q[`RQ_SIDE_TAIL +: 4];
  // messages in aligned mode go to lane zero
  assign eff_off = (!ctrl_q[`RQ_CTRL_ALIGN] | is_msg) ? 3'h0
                 : side_q[`RQ_SIDE_OFF +: 3];

  // descriptor with length forced to one for zero-length and own tag
  always_comb begin
    eff_desc = desc_q;
    if (zlen) begin
      eff_desc[`RQ_D_LEN +: 11] = 11'h001;
    end
    if (user_tag_mode_param && !is_wr && !is_msg) begin
      eff_desc[`RQ_D_TAG +: 6] = user_tag_q;
    end
  end

  // mask shape check; short memory writes may be scattered
  assign be_bad = !(zlen | is_msg) && !(is_wr && eff_len <= 11'h002) &&
                  !(contig4(head_m) && contig4(tail_m));
  // payload size and page crossing check
  assign size_bad = (eff_len != 11'h000) &&
                    (({1'b0, eff_len} > MAX_DW) ||
                     ({2'b00, desc_q[11:2]} + {1'b0, eff_len} >
                      `RQ_PAGE_DW));

  // ----------------------------------------------------------------
  // beat builder
  // ----------------------------------------------------------------
  logic [7:0] pk_beat;
  logic [LANES*32-1:0] pk_data;
  logic [LANES-1:0] pk_keep;
  logic pk_last, pk_pay;

  // always build the beat that is to be presented next
  assign pk_beat = (st_q == ST_IDLE) ? 8'h00 : beat_q + 8'h01;

  rq_beat_packer #(
    .LANES(LANES)
  ) u_packer (
    .beat(pk_beat),
    .aligned(ctrl_q[`RQ_CTRL_ALIGN]),
    .offset(eff_off),
    .len(eff_len),
    .desc(eff_desc),
    .seed(seed_q),
    .data(pk_data),
    .keep(pk_keep),
    .last(pk_last),
    .pay_beat(pk_pay)
  );

  // ----------------------------------------------------------------
  // apb slave: one wait-free access phase per transfer
  // ----------------------------------------------------------------
  logic setup, wr_en, hit;
  logic [31:0] rd_word;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_q & pwrite;

  // read mux, unmapped words read as zero and flag an error
  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `RQ_A_CTRL: rd_word = {27'h0000000, ctrl_q, 1'b0};
      `RQ_A_SIDE: rd_word = {21'h000000, side_q};
      `RQ_A_PLEN: rd_word = {21'h000000, plen_q};
      `RQ_A_SEED: rd_word = seed_q;
      `RQ_A_ABEAT: rd_word = {24'h000000, abeat_q};
      `RQ_A_STAT: rd_word = {16'h0000, done_q, 5'h00, err_size_q,
                             err_be_q, busy};
      `RQ_A_TAG: rd_word = {16'h0000, tag_cnt_q, 2'h0, last_tag_q};
      `RQ_A_DESC0: rd_word = desc_q[31:0];
      `RQ_A_DESC1: rd_word = desc_q[63:32];
      `RQ_A_DESC2: rd_word = desc_q[95:64];
      `RQ_A_DESC3: rd_word = desc_q[127:96];
      default: hit = 1'b0;
    endcase
  end

  // answer registered in setup so that pready rises in the access cycle
  always_comb begin
    pready_d = setup;
    pslverr_d = setup & ~hit;
    prdata_d = (setup & ~pwrite) ? rd_word : prdata_q;
  end

  // ----------------------------------------------------------------
  // configuration and status registers
  // ----------------------------------------------------------------
  logic set_be, set_size, pkt_done;

  // setup fields are frozen while a packet is in flight
  always_comb begin
    ctrl_d = ctrl_q;
    side_d = side_q;
    plen_d = plen_q;
    seed_d = seed_q;
    abeat_d = abeat_q;
    desc_d = desc_q;
    go_d = 1'b0;
    if (wr_en && !busy) begin
      unique case (paddr)
        `RQ_A_CTRL: begin
          ctrl_d = pwdata[4:1];
          go_d = pwdata[`RQ_CTRL_GO];
        end
        `RQ_A_SIDE: side_d = pwdata[10:0];
        `RQ_A_PLEN: plen_d = pwdata[10:0];
        `RQ_A_SEED: seed_d = pwdata;
        `RQ_A_ABEAT: abeat_d = pwdata[7:0];
        `RQ_A_DESC0: desc_d[31:0] = pwdata;
        `RQ_A_DESC1: desc_d[63:32] = pwdata;
        `RQ_A_DESC2: desc_d[95:64] = pwdata;
        `RQ_A_DESC3: desc_d[127:96] = pwdata;
        default: ;
      endcase
    end
  end

  // error flags: write one to clear, a new error in the same cycle wins
  always_comb begin
    logic w_stat;
    w_stat = wr_en && (paddr == `RQ_A_STAT);
    err_be_d = (err_be_q & ~(w_stat & pwdata[`RQ_STAT_ERR_BE])) | set_be;
    err_size_d = (err_size_q & ~(w_stat & pwdata[`RQ_STAT_ERR_SIZE])) |
                 set_size;
    done_d = pkt_done ? done_q + 8'h01 : done_q;
    user_tag_d = user_tag_q;
    if (pkt_done && !is_wr && !is_msg) begin
      user_tag_d = user_tag_q + 6'h01;
    end
  end

  // tags arrive in request order, so the latest one names the newest
  always_comb begin
    last_tag_d = allocated_tag_strobe ? allocated_tag_out : last_tag_q;
    tag_cnt_d = allocated_tag_strobe ? tag_cnt_q + 8'h01 : tag_cnt_q;
  end

  // ----------------------------------------------------------------
  // request stream sequencer
  // ----------------------------------------------------------------
  logic take, disc_now;
  assign take = valid_q & request_stream_ready;
  // abort starts at the chosen beat, only where payload is carried
  assign disc_now = ctrl_q[`RQ_CTRL_ABORT] & pk_pay & (pk_beat >= abeat_q);

  always_comb begin
    st_d = st_q;
    beat_d = beat_q;
    valid_d = valid_q;
    last_d = last_q;
    data_d = data_q;
    keep_d = keep_q;
    sb_d = sb_q;
    set_be = 1'b0;
    set_size = 1'b0;
    pkt_done = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (go_q) begin
          set_be = be_bad;
          set_size = size_bad;
          if (!be_bad && !size_bad) begin
            st_d = ST_SEND;
            beat_d = 8'h00;
            valid_d = 1'b1;
            data_d = pk_data;
            keep_d = pk_keep;
            last_d = pk_last | (disc_now & ctrl_q[`RQ_CTRL_AEND]);
            // masks and offset go out with the first beat
            sb_d.head_dword_byte_mask = head_m;
            sb_d.tail_dword_byte_mask = tail_m;
            sb_d.addr_offset = eff_off;
            sb_d.discontinue = disc_now;
          end
        end
      end
      ST_SEND: begin
        // everything holds while ready is low, valid never drops
        if (take) begin
          if (last_q) begin
            st_d = ST_DONE;
            valid_d = 1'b0;
            last_d = 1'b0;
            keep_d = '0;
            sb_d.discontinue = 1'b0;
          end else begin
            beat_d = beat_q + 8'h01;
            data_d = pk_data;
            keep_d = pk_keep;
            // once raised, discontinue stays up for the rest
            sb_d.discontinue = sb_q.discontinue | disc_now;
            last_d = pk_last | ((sb_q.discontinue | disc_now) &
                     ctrl_q[`RQ_CTRL_AEND]);
          end
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
        pkt_done = 1'b1;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 4'h0;
      side_q <= `RQ_RST_W11;
      plen_q <= `RQ_RST_W11;
      seed_q <= `RQ_RST_W32;
      abeat_q <= `RQ_RST_W8;
      desc_q <= '0;
      go_q <= 1'b0;
      err_be_q <= 1'b0;
      err_size_q <= 1'b0;
      done_q <= `RQ_RST_W8;
      last_tag_q <= `RQ_RST_TAG;
      tag_cnt_q <= `RQ_RST_W8;
      user_tag_q <= `RQ_RST_TAG;
      prdata_q <= `RQ_RST_W32;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      st_q <= ST_IDLE;
      beat_q <= `RQ_RST_W8;
      valid_q <= 1'b0;
      last_q <= 1'b0;
      data_q <= '0;
      keep_q <= '0;
      sb_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      side_q <= side_d;
      plen_q <= plen_d;
      seed_q <= seed_d;
      abeat_q <= abeat_d;
      desc_q <= desc_d;
      go_q <= go_d;
      err_be_q <= err_be_d;
      err_size_q <= err_size_d;
      done_q <= done_d;
      last_tag_q <= last_tag_d;
      tag_cnt_q <= tag_cnt_d;
      user_tag_q <= user_tag_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      st_q <= st_d;
      beat_q <= beat_d;
      valid_q <= valid_d;
      last_q <= last_d;
      data_q <= data_d;
      keep_q <= keep_d;
      sb_q <= sb_d;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign request_stream_data = data_q;
  assign request_stream_keep = keep_q;
  assign request_stream_last = last_q;
  assign request_stream_valid = valid_q;
  assign request_sideband_bus = sb_q;
endmodule

/* File: sim/rq_host_props.sv */
// ----------------------------------------------------------------
// port checks
// ----------------------------------------------------------------
module rq_host_props #(
  parameter int LANES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [LANES*32-1:0] request_stream_data,
  input wire logic [LANES-1:0] request_stream_keep,
  input wire logic request_stream_last,
  input wire logic request_stream_valid,
  input wire logic request_stream_ready,
  input wire rq_host_pkg::request_sideband_t request_sideband_bus
);
  import rq_host_pkg::*;
  logic vld, take, disc;
  logic [LANES-1:0] keep;
  // short aliases
  assign vld = request_stream_valid;
  assign take = vld && request_stream_ready;
  assign disc = request_sideband_bus.discontinue;
  assign keep = request_stream_keep;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  AST_PREADY_NEXT: assert property (s_setup |=> s_access)
    else $error("no ready");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_HOLD: assert property (vld && !request_stream_ready |=> vld &&
    $stable(request_stream_data) && $stable(keep) &&
    $stable(request_stream_last) && $stable(request_sideband_bus))
    else $error("beat moved");
  AST_VALID_TO_LAST: assert property (take && !request_stream_last |=> vld)
    else $error("valid dropped");
  AST_DISC_VALID: assert property (disc |-> vld)
    else $error("lone abort");
  AST_DISC_STICKY: assert property (take && disc && !request_stream_last
    |=> disc) else $error("abort fell");
  AST_KEEP_FULL: assert property (vld && !request_stream_last |-> &keep)
    else $error("keep hole");
  AST_KEEP_CONTIG: assert property (vld |-> keep[0] && ((keep + 1'b1) & keep) == '0)
    else $error("keep gap");
  AST_DESC_ONLY: assert property (vld && keep == {{(LANES-4){1'b0}}, 4'hF}
    |-> request_stream_last) else $error("desc not last");
  AST_DONE_GAP: assert property (take && request_stream_last |=> !vld [*2])
    else $error("no gap");
endmodule

/* File: sim/rq_device_model.sv */
// ----------------------------------------------------------------
// far-end device model
// ----------------------------------------------------------------
module rq_device_model #(
  parameter int LANES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall_en,
  input wire logic [LANES*32-1:0] request_stream_data,
  input wire logic request_stream_last,
  input wire logic request_stream_valid,
  output logic request_stream_ready,
  input wire rq_host_pkg::request_sideband_t request_sideband_bus,
  output logic [5:0] allocated_tag_out,
  output logic allocated_tag_strobe,
  output logic [7:0] nullify_cnt
);
  import rq_host_pkg::*;
  logic [1:0] cyc_q;
  logic in_pkt_q, np_q, disc_q, np_now, disc_now;
  logic [6:0] busy_q;
  logic [5:0] next_tag_q;
  // masks are never read: the end comes from last, or from valid dropping mid-packet
  assign np_now = in_pkt_q ? np_q : (request_stream_data[78:75] != 4'h1 &&
    request_stream_data[78:75] < 4'hC);
  assign disc_now = (disc_q && in_pkt_q) || request_sideband_bus.discontinue;
  // stall pattern lets three of four cycles stretch a beat
  assign request_stream_ready = presetn && busy_q < 7'h40 &&
    (!stall_en || cyc_q == 2'b00);
  // no completions: the table only fills
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= 2'b00;
      in_pkt_q <= 1'b0;
      np_q <= 1'b0;
      disc_q <= 1'b0;
      busy_q <= 7'h00;
      next_tag_q <= 6'h00;
      allocated_tag_out <= 6'h00;
      allocated_tag_strobe <= 1'b0;
      nullify_cnt <= 8'h00;
    end else begin
      cyc_q <= cyc_q + 2'b01;
      allocated_tag_strobe <= 1'b0;
      if (in_pkt_q && !request_stream_valid) begin
        nullify_cnt <= nullify_cnt + 8'h01;
        in_pkt_q <= 1'b0;
      end else if (request_stream_valid && request_stream_ready) begin
        in_pkt_q <= !request_stream_last;
        np_q <= np_now;
        disc_q <= disc_now;
        if (request_stream_last && disc_now) begin
          nullify_cnt <= nullify_cnt + 8'h01;
        end
        if (request_stream_last && np_now) begin
          allocated_tag_strobe <= 1'b1;
          allocated_tag_out <= next_tag_q;
          next_tag_q <= next_tag_q + 6'h01;
          busy_q <= busy_q + 7'h01;
        end
      end
    end
  end
endmodule

/* File: sim/pcie_requester_request_port_tb_top.sv */
`include "rq_host_consts.svh"
module pcie_requester_request_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rq_host_pkg::*;
  localparam int LANES = 8;
  typedef struct packed {
    logic [4:0] ctrl;
    logic [10:0] side;
    logic [10:0] plen;
    logic [3:0] typ;
    logic [31:0] addr;
  } row_t;
  // ctrl, offset and masks, length, type, address
  localparam row_t ROWS [14] = '{
    '{5'h00, 11'h0FF, 11'h002, 4'h1, 32'h100},
    '{5'h00, 11'h0A5, 11'h002, 4'h1, 32'h108},
    '{5'h00, 11'h0FF, 11'h00D, 4'h1, 32'h200},
    '{5'h00, 11'h0FF, 11'h008, 4'h1, 32'hFE0},
    '{5'h00, 11'h0FF, 11'h100, 4'h1, 32'h000},
    '{5'h02, 11'h3FF, 11'h005, 4'h1, 32'h30C},
    '{5'h02, 11'h5FF, 11'h004, 4'h0, 32'h400},
    '{5'h00, 11'h0FF, 11'h010, 4'h0, 32'h480},
    '{5'h02, 11'h6FF, 11'h002, 4'hC, 32'h000},
    '{5'h00, 11'h0FF, 11'h001, 4'hD, 32'h000},
    '{5'h00, 11'h0FF, 11'h000, 4'hE, 32'h000},
    '{5'h00, 11'h0FF, 11'h003, 4'hF, 32'h000},
    '{5'h04, 11'h000, 11'h001, 4'h1, 32'h500},
    '{5'h04, 11'h000, 11'h000, 4'h0, 32'h600}};
  localparam logic [7:0] RST_A [3] = '{`RQ_A_CTRL, `RQ_A_STAT, `RQ_A_TAG};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic stall_en = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, slast, svalid, sready, tag_stb, er;
  logic [LANES*32-1:0] sdata;
  logic [LANES-1:0] skeep;
  logic [5:0] tag;
  logic [7:0] nullified, last_keep;
  request_sideband_t sband, sb_first;
  logic [31:0] pos_q [$];
  int bad_count = 0, tests_run = 0, pkt_cnt = 0;
  int disc_beats = 0, cycles = 0, np_cnt = 0;
  always #12.5 pclk = ~pclk;
  rq_host_ctrl #(.LANES(LANES)) rq_host_ctrl_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .request_stream_data(sdata),
    .request_stream_keep(skeep), .request_stream_last(slast),
    .request_stream_valid(svalid), .request_stream_ready(sready),
    .request_sideband_bus(sband), .allocated_tag_out(tag),
    .allocated_tag_strobe(tag_stb));
  rq_device_model #(.LANES(LANES)) rq_device_model_inst (.pclk,
    .presetn, .stall_en, .request_stream_data(sdata),
    .request_stream_last(slast), .request_stream_valid(svalid),
    .request_stream_ready(sready), .request_sideband_bus(sband),
    .allocated_tag_out(tag), .allocated_tag_strobe(tag_stb),
    .nullify_cnt(nullified));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // held until pready is seen high at an edge, released after it
  task automatic apb(logic [7:0] a, logic [31:0] d, logic w = 1'b1);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(row_t r, logic [7:0] abeat, logic wt);
    int n0;
    apb(`RQ_A_SIDE, {21'h0, r.side});
    apb(`RQ_A_PLEN, {21'h0, r.plen});
    apb(`RQ_A_SEED, 32'hC0DE_0000);
    apb(`RQ_A_ABEAT, {24'h0, abeat});
    apb(`RQ_A_DESC0, r.addr);
    apb(`RQ_A_DESC2, {17'h0, r.typ, r.plen});
    n0 = pkt_cnt;
    pos_q.delete();
    disc_beats = 0;
    apb(`RQ_A_CTRL, {27'h0, r.ctrl | 5'h01});
    if (wt) begin
      while (pkt_cnt == n0) @(posedge pclk);
      repeat (3) @(posedge pclk);
    end
  endtask
  task automatic check_row(row_t r);
    int pay, st, tot, beats;
    logic msg, zl, rdq;
    msg = r.typ >= 4'hC;
    zl = r.ctrl[2];
    rdq = r.typ == 4'h0;
    pay = rdq ? 0 : (zl ? 1 : int'(r.plen));
    st = r.ctrl[1] ? LANES + (msg ? 0 : int'(r.side[10:8])) : 4;
    tot = pay > 0 ? st + pay : 4;
    beats = (tot + LANES - 1) / LANES;
    cmp("positions", beats * LANES, pos_q.size());
    cmp("last keep", 32'hFF >> (beats * LANES - tot), last_keep);
    cmp("desc addr", r.addr, pos_q[0]);
    cmp("desc len", {17'h0, r.typ, (zl && rdq) ? 11'h001 : r.plen},
        pos_q[2]);
    cmp("masks", (msg || zl) ? 32'h0 : r.side[7:0], sb_first[7:0]);
    if (r.ctrl[1])
      cmp("offset", msg ? 3'h0 : r.side[10:8], sb_first.addr_offset);
    for (int i = 0; i < pay && !zl; i++)
      cmp("payload", 32'hC0DE_0000 + i, pos_q[st + i]);
  endtask
  task automatic err_case(row_t r, int bitn);
    int n0;
    n0 = pkt_cnt;
    send(r, 8'h00, 1'b0);
    repeat (6) @(posedge pclk);
    cmp("refused packet", n0, pkt_cnt);
    apb(`RQ_A_STAT, 32'h0, 1'b0);
    cmp("error flag", 32'h1 << bitn, rd & 32'h7);
    apb(`RQ_A_STAT, 32'h1 << bitn);
  endtask
  // ----------------------------------------------------------------
  // stream monitor and hang limit
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      end_of_test();
    end
    if (svalid === 1'b1 && sready === 1'b1) begin
      if (pos_q.size() == 0)
        sb_first = sband;
      for (int k = 0; k < LANES; k++)
        pos_q.push_back(sdata[k*32 +: 32]);
      disc_beats += int'(sband.discontinue);
      if (slast === 1'b1) begin
        last_keep = skeep;
        pkt_cnt++;
      end
    end
  end
  // reset, rows, refusals, aborts, status
  initial begin
    repeat (3) @(posedge pclk);
    cmp("valid in reset", 32'h0, svalid);
    cmp("ready in reset", 32'h0, pready);
    presetn <= 1'b1;
    for (int a = 0; a < 3; a++) begin
      apb(RST_A[a], 32'h0, 1'b0);
      cmp("reset value", 32'h0, rd);
    end
    foreach (ROWS[i]) begin
      stall_en <= i[0];
      send(ROWS[i], 8'h00, 1'b1);
      check_row(ROWS[i]);
      np_cnt += int'(ROWS[i].typ == 4'h0);
    end
    err_case('{5'h00, 11'h0F5, 11'h004, 4'h0, 32'h800}, 1);
    err_case('{5'h00, 11'h0A5, 11'h003, 4'h1, 32'h800}, 1);
    err_case('{5'h00, 11'h0FF, 11'h12C, 4'h1, 32'h000}, 2);
    err_case('{5'h00, 11'h0FF, 11'h008, 4'h1, 32'hFF0}, 2);
    stall_en <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      send('{e ? 5'h18 : 5'h08, 11'h0FF, 11'h014, 4'h1, 32'h700}, 8'h01,
           1'b1);
      cmp("abort positions", e ? 16 : 24, pos_q.size());
      cmp("abort beats", e ? 1 : 2, disc_beats);
    end
    cmp("nullified", 32'h2, nullified);
    apb(`RQ_A_TAG, 32'h0, 1'b0);
    cmp("tag", (np_cnt << 8) | (np_cnt - 1), rd & 32'hFF3F);
    apb(`RQ_A_STAT, 32'h0, 1'b0);
    cmp("status", pkt_cnt << 8, rd & 32'hFF07);
    apb(8'h40, 32'h0, 1'b0);
    cmp("unmapped err", 32'h1, er);
    cmp("unmapped data", 32'h0, rd);
    end_of_test();
  end
endmodule

bind rq_host_ctrl rq_host_props #(.LANES(LANES)) rq_host_props_inst (
  .pclk, .presetn, .psel, .penable, .pready, .request_stream_data,
  .request_stream_keep, .request_stream_last, .request_stream_valid,
  .request_stream_ready, .request_sideband_bus);
